// ---- rtl/tstf_top.sv ----
// Command and torque filter block with AXI4-Lite settings and an input FIFO.
// Assumes one 100 MHz clock, synchronous active-low reset, inputs synchronous.
`timescale 1ns/1ps

module tstf_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input  wire logic         aclk,      // Clock
  input  wire logic         aresetn,   // Sync reset, active low
  input  wire logic         in_valid,  // Write side valid
  output logic              in_ready,  // Not full
  input  wire logic [W-1:0] in_data,   // Write data
  output logic              out_valid, // Not empty
  input  wire logic         out_ready, // Read side ready
  output logic [W-1:0]      out_data   // Head word
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  if ((1 << AW) != D) begin : g_chk
    $error("FIFO depth must be a power of two");
  end
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;
  assign in_ready  = (cnt_q != AW'(0) + (AW+1)'(D)) ;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rp_q];
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_q + AW'(push);
      rp_q  <= rp_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  a_fifo_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_q <= (AW+1)'(D)) else $error("FIFO count above depth");
endmodule

module tstf_top #(
  parameter int CTRL_DIV = tstf_pkg::CTRL_DIV,
  parameter int FIFO_D   = 8
) (
  input  wire logic        aclk,        // Clock
  input  wire logic        aresetn,     // Sync reset, active low
  input  wire logic [7:0]  awaddr,      // AXI write address
  input  wire logic        awvalid,     // AXI
  output logic             awready,     // AXI
  input  wire logic [31:0] wdata,       // AXI
  input  wire logic [3:0]  wstrb,       // AXI
  input  wire logic        wvalid,      // AXI
  output logic             wready,      // AXI
  output logic [1:0]       bresp,       // AXI
  output logic             bvalid,      // AXI
  input  wire logic        bready,      // AXI
  input  wire logic [7:0]  araddr,      // AXI read address
  input  wire logic        arvalid,     // AXI
  output logic             arready,     // AXI
  output logic [31:0]      rdata,       // AXI
  output logic [1:0]       rresp,       // AXI
  output logic             rvalid,      // AXI
  input  wire logic        rready,      // AXI
  input  wire logic        servo_on,    // Servo on level
  input  wire logic        smp_valid,   // Sample pair valid
  output logic             smp_ready,   // FIFO has room
  input  wire logic [15:0] cmd_in,      // Signed command sample
  input  wire logic [15:0] torque_in,   // Signed torque sample
  output logic             out_valid,   // One pulse per control cycle that takes a sample pair
  output logic [15:0]      cmd_out,     // Filtered command
  output logic [15:0]      torque_out   // Filtered torque
);
  if (CTRL_DIV < 1 || FIFO_D < 2) begin : g_chk
    $error("Bad divider or FIFO depth");
  end
  localparam int ACCW = 16 + tstf_pkg::FRAC + 1;

  // Shift for a first-order step: bit length of the time constant, at most 12
  function automatic logic [3:0] tc_sh(input logic [15:0] tc);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 0; i < 12; i++) begin
      if (tc[i]) s = 4'(i + 1);
    end
    if (|tc[15:12]) s = 4'hc;
    return s;
  endfunction

  function automatic logic signed [ACCW-1:0] lp_step(
    input logic signed [ACCW-1:0] acc, input logic [15:0] x, input logic [3:0] sh);
    logic signed [ACCW-1:0] xs;
    xs = ACCW'(signed'(x)) <<< tstf_pkg::FRAC;
    return (sh == 4'h0) ? xs : acc + ((xs - acc) >>> sh);
  endfunction

  function automatic logic [15:0] wmerge(
    input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
    return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [15:0] sat(input logic [15:0] v, input logic [15:0] mx);
    return (v > mx) ? mx : v;
  endfunction

  // Register bus
  logic [15:0] fexp_q, lp_q, fir_q, adj_q, tc3_q, att3_q, nv_q;
  logic        en_app_q, bvalid_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  wire         wr_fire = awvalid && wvalid && !bvalid_q;
  wire         rd_fire = arvalid && !rvalid_q;
  wire [7:0]   wa = {awaddr[7:2], 2'h0};
  wire [7:0]   ra = {araddr[7:2], 2'h0};
  wire         wr_map = wa <= tstf_pkg::OFS_STATUS;
  wire         rd_map = ra <= tstf_pkg::OFS_STATUS;
  wire         do_save    = wr_fire && wa == tstf_pkg::OFS_CTRL && wstrb[0]
                            && wdata[tstf_pkg::BIT_SAVE];
  wire         do_restart = wr_fire && wa == tstf_pkg::OFS_CTRL && wstrb[0]
                            && wdata[tstf_pkg::BIT_RESTART];
  wire [15:0]  tc3_w = sat(wmerge(tc3_q, wdata, wstrb), tstf_pkg::TF3_TC_MAX);
  wire [15:0]  att3_w = sat(wmerge(att3_q, wdata, wstrb), tstf_pkg::TF3_ATT_MAX);

  assign awready = wr_fire;
  assign wready  = wr_fire;
  assign arready = rd_fire;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;

  // Applied parameters
  wire         rt_sel = en_app_q && fexp_q[tstf_pkg::BIT_RT_SEL];
  wire [15:0]  lp_app = rt_sel ? sat(lp_q, tstf_pkg::LP_RT_MAX) : lp_q;
  wire         ord2   = att3_q >= tstf_pkg::TF3_ATT_2ND;
  wire [15:0]  tc3_lo = (tc3_q < tstf_pkg::TF3_TC_MIN2) ? tstf_pkg::TF3_TC_MIN2 : tc3_q;
  wire [15:0]  tc3_app = ord2 ? sat(tc3_lo, tstf_pkg::TF3_TC_MAX2) : tc3_q;
  wire         tf3_byp = (tc3_q == 16'h0000) || !servo_on;

  logic [31:0] stat_w;
  assign stat_w = {14'h0, ord2, en_app_q, lp_app};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fexp_q <= tstf_pkg::RST_FUNC_EXP;
      lp_q   <= tstf_pkg::RST_TC;
      fir_q  <= tstf_pkg::RST_TC;
      adj_q  <= tstf_pkg::RST_TC;
      tc3_q  <= tstf_pkg::RST_TC;
      att3_q <= tstf_pkg::RST_TF3_ATT;
    end else if (wr_fire) begin
      case (wa)
        tstf_pkg::OFS_FUNC_EXP: fexp_q <= wmerge(fexp_q, wdata, wstrb);
        tstf_pkg::OFS_CMD_LP:   lp_q   <= wmerge(lp_q, wdata, wstrb);
        tstf_pkg::OFS_CMD_FIR:  fir_q  <= wmerge(fir_q, wdata, wstrb);
        tstf_pkg::OFS_ADJ:      adj_q  <= wmerge(adj_q, wdata, wstrb);
        tstf_pkg::OFS_TF3_TC:   tc3_q  <= tc3_w;
        tstf_pkg::OFS_TF3_ATT:  att3_q <= att3_w;
        default: ;
      endcase
    end
  end

  // Saved copy and applied enable: restart stands in for a control power cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_q     <= tstf_pkg::RST_FUNC_EXP;
      en_app_q <= 1'b0;
    end else begin
      if (do_save) nv_q <= fexp_q;
      if (do_restart) en_app_q <= nv_q[tstf_pkg::BIT_EN];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= tstf_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= tstf_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map && wa != tstf_pkg::OFS_STATUS ? tstf_pkg::RESP_OKAY
                                                         : tstf_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rd_map ? tstf_pkg::RESP_OKAY : tstf_pkg::RESP_SLVERR;
        case (ra)
          tstf_pkg::OFS_FUNC_EXP: rdata_q <= {16'h0, fexp_q};
          tstf_pkg::OFS_CMD_LP:   rdata_q <= {16'h0, lp_q};
          tstf_pkg::OFS_CMD_FIR:  rdata_q <= {16'h0, fir_q};
          tstf_pkg::OFS_ADJ:      rdata_q <= {16'h0, adj_q};
          tstf_pkg::OFS_TF3_TC:   rdata_q <= {16'h0, tc3_q};
          tstf_pkg::OFS_TF3_ATT:  rdata_q <= {16'h0, att3_q};
          tstf_pkg::OFS_STATUS:   rdata_q <= stat_w;
          default:                rdata_q <= 32'h0000_0000;
        endcase
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Control cycle divider
  logic [15:0] div_q;
  wire         tick = (div_q == 16'(CTRL_DIV - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) div_q <= 16'h0000;
    else div_q <= tick ? 16'h0000 : div_q + 16'h0001;
  end

  // Input FIFO; at most one sample pair leaves per control cycle
  logic        f_valid;
  logic [31:0] f_data;
  wire         step = tick && f_valid;
  tstf_fifo #(.W(32), .D(FIFO_D)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (smp_valid),
    .in_ready  (smp_ready),
    .in_data   ({cmd_in, torque_in}),
    .out_valid (f_valid),
    .out_ready (tick),
    .out_data  (f_data)
  );
  wire [15:0]  x_cmd = f_data[31:16];
  wire [15:0]  x_trq = f_data[15:0];

  // Command path: lowpass, FIR moving average, adjustment filter
  logic signed [ACCW-1:0] lp_acc_q, adj_acc_q, t1_acc_q, t2_acc_q;
  logic [15:0]            hist_q [8];
  wire  [3:0]             lp_sh  = tc_sh(lp_app);
  wire  [3:0]             fsh_r  = tc_sh(fir_q);
  wire  [1:0]             fir_sh = (fsh_r > 4'h3) ? 2'h3 : fsh_r[1:0];
  wire  signed [ACCW-1:0] lp_nx  = lp_step(lp_acc_q, x_cmd, lp_sh);
  wire  [15:0]            lp_out = 16'(lp_nx >>> tstf_pkg::FRAC);
  logic signed [19:0]     fir_sum;
  always_comb begin
    fir_sum = 20'(signed'(lp_out));
    for (int i = 0; i < 7; i++) begin
      if (i < (1 << fir_sh) - 1) fir_sum = fir_sum + 20'(signed'(hist_q[i]));
    end
  end
  wire  [15:0]            fir_out = 16'(fir_sum >>> fir_sh);
  wire  signed [ACCW-1:0] adj_nx  = lp_step(adj_acc_q, fir_out, tc_sh(adj_q));

  // Third torque filter: one stage, or two cascaded stages for second order
  wire  [3:0]             t_sh  = tc_sh(tc3_app);
  wire  signed [ACCW-1:0] t1_nx = lp_step(t1_acc_q, x_trq, t_sh);
  wire  [15:0]            t1_o  = 16'(t1_nx >>> tstf_pkg::FRAC);
  wire  signed [ACCW-1:0] t2_nx = lp_step(t2_acc_q, t1_o, t_sh);
  wire  [15:0]            t3_o  = tf3_byp ? x_trq
                                  : ord2 ? 16'(t2_nx >>> tstf_pkg::FRAC) : t1_o;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lp_acc_q  <= '0;
      adj_acc_q <= '0;
      t1_acc_q  <= '0;
      t2_acc_q  <= '0;
    end else if (step) begin
      lp_acc_q  <= lp_nx;
      adj_acc_q <= adj_nx;
      t1_acc_q  <= tf3_byp ? ACCW'(signed'(x_trq)) <<< tstf_pkg::FRAC : t1_nx;
      t2_acc_q  <= tf3_byp ? ACCW'(signed'(x_trq)) <<< tstf_pkg::FRAC : t2_nx;
    end
  end

  for (genvar g = 0; g < 8; g++) begin : g_hist
    always_ff @(posedge aclk) begin
      if (!aresetn) hist_q[g] <= 16'h0000;
      else if (step) hist_q[g] <= (g == 0) ? lp_out : hist_q[(g == 0) ? 0 : g - 1];
    end
  end

  logic        ov_q;
  logic [15:0] co_q, to_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ov_q <= 1'b0;
      co_q <= 16'h0000;
      to_q <= 16'h0000;
    end else begin
      ov_q <= step;
      if (step) begin
        co_q <= en_app_q ? 16'(adj_nx >>> tstf_pkg::FRAC) : x_cmd;
        to_q <= t3_o;
      end
    end
  end
  assign out_valid  = ov_q;
  assign cmd_out    = co_q;
  assign torque_out = to_q;

  a_en_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(en_app_q) |-> $past(do_restart)) else $error("Enable changed without restart");
  a_en_load: assert property (@(posedge aclk) disable iff (!aresetn)
    do_restart |=> en_app_q == $past(nv_q[0])) else $error("Enable not loaded");
  a_lp_clamp: assert property (@(posedge aclk) disable iff (!aresetn)
    rt_sel && lp_q > 16'h0280 |-> lp_app == 16'h0280) else $error("Lowpass not clamped");
  a_lp_stored: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(lp_q) |-> $past(wr_fire && wa == 8'h04)) else $error("Stored lowpass altered");
  a_tc3_range: assert property (@(posedge aclk) disable iff (!aresetn)
    tc3_q <= 16'h09c4) else $error("Time constant above range");
  a_tf3_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    step && tc3_q == 16'h0 |=> torque_out == $past(x_trq)) else $error("Bypass failed");
  a_tf3_ord2: assert property (@(posedge aclk) disable iff (!aresetn)
    ord2 |-> tc3_app >= 16'h0005 && tc3_app <= 16'h009f) else $error("Second order range");
  a_att_range: assert property (@(posedge aclk) disable iff (!aresetn)
    att3_q <= 16'h03e8 && (att3_q < 16'h0032) == !ord2) else $error("Attenuation order");
  a_out_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    out_valid |-> $past(tick) && !$past(out_valid)) else $error("Output off cycle");
endmodule

// ---- rtl/tstf_pkg.sv ----
// Two-stage torque command filter: shared register map, fields and limits.
// Assumes a 32-bit AXI4-Lite register bus and 16-bit signed sample streams.
// Operation
// - Bit 0 of the function expansion setting enables two-degree-of-freedom control.
// - A changed enable takes effect only after save and a control restart.
// - With real-time auto-tuning selected, applied lowpass constant clamps at 640; the code clamps only while the two-degree-of-freedom enable is applied.
// - Clamping limits only the applied value; the stored setting stays intact.
// - A smaller lowpass time constant gives a faster command response.
// - Two-degree-of-freedom path filters the command through an FIR stage.
// - A separate adjustment filter with its own constant follows in that path.
// - A third torque filter acts on the torque command.
// - Third torque filter time constant accepts 0 to 2500.
// - Time constant zero bypasses the third torque filter.
// - Second-order operation uses effective time constants 5 to 159.
// - Second order treats settings 1..4 as 5 and 159 upward as 159.
// - Attenuation accepts 0 to 1000; 0 to 49 runs first order.
// - Attenuation 50 to 1000 runs second order, critically damped at 1000.
// - Third torque filter works in every control mode while servo is on.
package tstf_pkg;
  localparam logic [7:0]  OFS_FUNC_EXP = 8'h00;
  localparam logic [7:0]  OFS_CMD_LP   = 8'h04;
  localparam logic [7:0]  OFS_CMD_FIR  = 8'h08;
  localparam logic [7:0]  OFS_ADJ      = 8'h0c;
  localparam logic [7:0]  OFS_TF3_TC   = 8'h10;
  localparam logic [7:0]  OFS_TF3_ATT  = 8'h14;
  localparam logic [7:0]  OFS_CTRL     = 8'h18;
  localparam logic [7:0]  OFS_STATUS   = 8'h1c;
  localparam int          BIT_EN       = 0;
  localparam int          BIT_RT_SEL   = 3;
  localparam int          BIT_SAVE     = 0;
  localparam int          BIT_RESTART  = 1;
  localparam logic [15:0] RST_FUNC_EXP = 16'h0000;
  localparam logic [15:0] RST_TC       = 16'h0000;
  localparam logic [15:0] RST_TF3_ATT  = 16'h03e8;
  localparam logic [15:0] LP_RT_MAX    = 16'h0280;
  localparam logic [15:0] TF3_TC_MAX   = 16'h09c4;
  localparam logic [15:0] TF3_TC_MIN2  = 16'h0005;
  localparam logic [15:0] TF3_TC_MAX2  = 16'h009f;
  localparam logic [15:0] TF3_ATT_MAX  = 16'h03e8;
  localparam logic [15:0] TF3_ATT_2ND  = 16'h0032;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam int          FRAC         = 8;
  localparam int          CTRL_DIV     = 8;
endpackage

// ---- bench/testbench.sv ----
// Self-checking bench for the command and torque filter block.
// Assumes tstf_pkg is compiled first; drives AXI4-Lite and the sample stream directly.
`timescale 1ns/1ps

module testbench;
  logic        aclk       = 1'b0;
  logic        aresetn    = 1'b0;
  logic [7:0]  awaddr     = 8'h00;
  logic [7:0]  araddr     = 8'h00;
  logic        awvalid    = 1'b0;
  logic        wvalid     = 1'b0;
  logic        arvalid    = 1'b0;
  logic        bready     = 1'b1;
  logic        rready     = 1'b1;
  logic [31:0] wdata      = 32'h0;
  logic [3:0]  wstrb      = 4'hf;
  logic        servo_on   = 1'b1;
  logic        smp_valid  = 1'b0;
  logic [15:0] cmd_in     = 16'h0;
  logic [15:0] torque_in  = 16'h0;
  logic        awready, wready, bvalid, arready, rvalid, smp_ready, out_valid;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [15:0] cmd_out, torque_out;
  logic        mon_on     = 1'b0;
  logic [31:0] exp_q[$];
  int          num_errors = 0;
  int          n_checks   = 0;

  always #5 aclk = ~aclk;

  tstf_top #(.CTRL_DIV(8), .FIFO_D(8)) u_tstf_top (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .servo_on(servo_on),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .cmd_in(cmd_in), .torque_in(torque_in),
    .out_valid(out_valid), .cmd_out(cmd_out), .torque_out(torque_out)
  );

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk2(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!(awready && wready) && n < 100);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!bvalid && n < 200);
    r = bresp;
    if (n >= 200) num_errors++;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 100);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < 200);
    d = rdata;
    r = rresp;
    if (n >= 200) num_errors++;
  endtask

  // Output pairs must come out in push order when the filters are bypassed
  always @(posedge aclk) begin
    if (mon_on && out_valid) begin
      if (exp_q.size() == 0) chk32("extra pair", 32'h0, 32'hffffffff);
      else chk32("stream pair", exp_q.pop_front(), {cmd_out, torque_out});
    end
  end

  task automatic push(input logic [15:0] c, input logic [15:0] t);
    int n;
    n = 0;
    cmd_in <= c;
    torque_in <= t;
    smp_valid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!smp_ready && n < 100);
    exp_q.push_back({c, t});
    smp_valid <= 1'b0;
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 400) begin
      @(posedge aclk);
      n++;
    end
    @(posedge aclk);
    chk32("queue left", 32'h0, exp_q.size());
  endtask

  task automatic t_reset_map();
    axi_rd(tstf_pkg::OFS_FUNC_EXP, rd, rs);
    chk32("func_exp reset", 32'h0, rd);
    chk2("mapped rresp", tstf_pkg::RESP_OKAY, rs);
    axi_rd(tstf_pkg::OFS_TF3_ATT, rd, rs);
    chk32("att reset", 32'h3e8, rd);
    axi_rd(8'h20, rd, rs);
    chk2("unmapped rresp", tstf_pkg::RESP_SLVERR, rs);
    chk32("unmapped data", 32'h0, rd);
    axi_wr(tstf_pkg::OFS_STATUS, 32'h1, rs);
    chk2("status write", tstf_pkg::RESP_SLVERR, rs);
  endtask

  task automatic t_saturate();
    axi_wr(tstf_pkg::OFS_TF3_TC, 32'h9c4, rs);
    axi_rd(tstf_pkg::OFS_TF3_TC, rd, rs);
    chk32("tc 2500", 32'h9c4, rd);
    axi_wr(tstf_pkg::OFS_TF3_TC, 32'hbb8, rs);
    axi_rd(tstf_pkg::OFS_TF3_TC, rd, rs);
    chk32("tc above range", 32'h9c4, rd);
    axi_wr(tstf_pkg::OFS_TF3_ATT, 32'h3e9, rs);
    axi_rd(tstf_pkg::OFS_TF3_ATT, rd, rs);
    chk32("att above range", 32'h3e8, rd);
  endtask

  task automatic t_bypass_stream();
    axi_wr(tstf_pkg::OFS_TF3_TC, 32'h0, rs);
    mon_on = 1'b1;
    for (int i = 0; i < 3; i++) begin
      push(16'h0100 + i, 16'hff00 - i);
      drain();
    end
    axi_wr(tstf_pkg::OFS_TF3_TC, 32'h64, rs);
    servo_on <= 1'b0;
    push(16'h0123, 16'h0321);
    drain();
    servo_on <= 1'b1;
    mon_on = 1'b0;
  endtask

  task automatic t_filter_active();
    int n;
    n = 0;
    axi_wr(tstf_pkg::OFS_TF3_ATT, 32'h0, rs);
    push(16'h0000, 16'h4000);
    while (!out_valid && n < 100) begin
      @(posedge aclk);
      n++;
    end
    chk32("tf3 smooths step", 32'h1, {31'h0, torque_out !== 16'h4000});
    exp_q.delete();
    @(posedge aclk);
  endtask

  task automatic t_fifo_full();
    int n;
    logic full;
    n = 0;
    full = 1'b0;
    axi_wr(tstf_pkg::OFS_TF3_TC, 32'h0, rs);
    mon_on = 1'b1;
    smp_valid <= 1'b1;
    while (!full && n < 20) begin
      @(posedge aclk);
      n++;
      if (!smp_ready) full = 1'b1;
      else exp_q.push_back({cmd_in, torque_in});
      cmd_in <= cmd_in + 16'h1;
      torque_in <= torque_in + 16'h10;
    end
    smp_valid <= 1'b0;
    chk32("fifo refused", 32'h1, {31'h0, full});
    drain();
    chk32("fifo empty", 32'h1, {31'h0, smp_ready});
    mon_on = 1'b0;
  endtask

  task automatic t_order_switch();
    logic [15:0] att[4] = '{16'h0000, 16'h0031, 16'h0032, 16'h03e8};
    servo_on <= 1'b0;
    axi_wr(tstf_pkg::OFS_TF3_TC, 32'h64, rs);
    for (int i = 0; i < 4; i++) begin
      axi_wr(tstf_pkg::OFS_TF3_ATT, {16'h0, att[i]}, rs);
      axi_rd(tstf_pkg::OFS_STATUS, rd, rs);
      chk32("second order flag", {31'h0, i >= 2}, {31'h0, rd[17]});
    end
    servo_on <= 1'b1;
  endtask

  // Two-dof path: zero constants pass the command, FIR smooths a step
  task automatic t_cmd_path();
    int n;
    n = 0;
    axi_wr(tstf_pkg::OFS_CMD_LP, 32'h0, rs);
    chk2("mapped bresp", tstf_pkg::RESP_OKAY, rs);
    axi_wr(tstf_pkg::OFS_CMD_FIR, 32'h0, rs);
    axi_wr(tstf_pkg::OFS_ADJ, 32'h0, rs);
    axi_wr(tstf_pkg::OFS_TF3_TC, 32'h0, rs);
    mon_on = 1'b1;
    push(16'h0200, 16'h0011);
    drain();
    mon_on = 1'b0;
    axi_wr(tstf_pkg::OFS_CMD_FIR, 32'h4, rs);
    push(16'h0800, 16'h0000);
    while (!out_valid && n < 100) begin
      @(posedge aclk);
      n++;
    end
    chk32("fir averages step", 32'h1, {31'h0, cmd_out !== 16'h0800});
    exp_q.delete();
    @(posedge aclk);
  endtask

  task automatic t_enable_apply();
    axi_wr(tstf_pkg::OFS_FUNC_EXP, 32'h1, rs);
    axi_rd(tstf_pkg::OFS_STATUS, rd, rs);
    chk32("enable before save", 32'h0, {31'h0, rd[16]});
    axi_wr(tstf_pkg::OFS_CTRL, 32'h1, rs);
    axi_rd(tstf_pkg::OFS_STATUS, rd, rs);
    chk32("enable before restart", 32'h0, {31'h0, rd[16]});
    axi_wr(tstf_pkg::OFS_CTRL, 32'h2, rs);
    axi_rd(tstf_pkg::OFS_STATUS, rd, rs);
    chk32("enable applied", 32'h1, {31'h0, rd[16]});
  endtask

  task automatic t_lp_clamp();
    axi_wr(tstf_pkg::OFS_FUNC_EXP, 32'h9, rs);
    axi_wr(tstf_pkg::OFS_CMD_LP, 32'h3e8, rs);
    axi_rd(tstf_pkg::OFS_CMD_LP, rd, rs);
    chk32("stored lowpass", 32'h3e8, rd);
    axi_rd(tstf_pkg::OFS_STATUS, rd, rs);
    chk32("applied lowpass", {16'h0, tstf_pkg::LP_RT_MAX}, {16'h0, rd[15:0]});
    axi_wr(tstf_pkg::OFS_FUNC_EXP, 32'h1, rs);
    axi_rd(tstf_pkg::OFS_STATUS, rd, rs);
    chk32("lowpass unclamped", 32'h3e8, {16'h0, rd[15:0]});
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #500000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_map();
    t_saturate();
    t_bypass_stream();
    t_filter_active();
    t_fifo_full();
    t_order_switch();
    t_enable_apply();
    t_lp_clamp();
    t_cmd_path();
    report_and_stop();
  end
endmodule
